// ---- uaw_pkg.sv ----
// constants, types and register map of the user alarm and warning unit
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package uaw_pkg;
    localparam int NUM_ALARMS = 8;
    localparam int NUM_WARNS = 4;
    localparam int GRP_W = 8;
    localparam int SRC_W = 6;
    localparam int DLY_W = 11;
    localparam int CNT_W = 12;
    localparam logic [DLY_W-1:0] DELAY_MAX_S = 11'h4B0;
    // one second time base
    localparam int SEC_PERIOD_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEC_CYCLES = SEC_PERIOD_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0]
    {
        MODE_ALWAYS,
        MODE_RUN_CMD,
        MODE_CLOSED_LOOP,
        MODE_OFF
    } uaw_mode_t;
    // register map
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_ALM_CFG = 12'h040;
    localparam logic [11:0] OFS_WRN_CFG = 12'h060;
    localparam logic [11:0] OFS_ALM_TXT = 12'h100;
    localparam logic [11:0] OFS_WRN_TXT = 12'h200;
    localparam int CTRL_FAULT_RST_BIT = 0;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SRC_LSB = 8;
    localparam int CFG_DLY_LSB = 16;
    localparam int ST_WARN_LSB = 8;
    localparam int ST_STOP_BIT = 12;
    localparam int ALM_TXT_WORDS = 3;
    localparam int WRN_TXT_WORDS = 2;
    localparam logic [1:0] PFX_WORD = 2'h3;
    localparam logic [15:0] PFX_LETTERS = 16'h5541;
    localparam logic [7:0] PFX_DIGIT_ONE = 8'h31;
    localparam logic [7:0] PFX_COLON = 8'h3A;
    // reset values
    localparam uaw_mode_t MODE_RST = MODE_OFF;
    localparam logic [SRC_W-1:0] SRC_RST = 6'h00;
    localparam logic [DLY_W-1:0] DLY_RST = 11'h000;
    localparam logic [31:0] TXT_RST = 32'h20202020;
endpackage

// ---- uaw_qual_if.sv ----
// carrier between the unit and one alarm delay qualifier
`timescale 1ns/1ps
interface uaw_qual_if;
    logic enable;
    logic cond;
    logic tick;
    logic [uaw_pkg::DLY_W-1:0] delay;
    logic qualified;
    modport ctrl (output enable, cond, tick, delay, input qualified);
    modport chan (input enable, cond, tick, delay, output qualified);
endinterface

// ---- uaw_alarm_qual.sv ----
// delay-on qualifier of one alarm channel
`timescale 1ns/1ps
module uaw_alarm_qual
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // channel link
    uaw_qual_if.chan q
);
    logic [uaw_pkg::CNT_W-1:0] cnt_ff;
    logic held;

    assign held = q.enable & q.cond;

    // the first second is partial, so count one tick past the delay to
    // guarantee at least the set time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else if (!held)
            cnt_ff <= '0;
        else if (q.tick && cnt_ff != '1)
            cnt_ff <= cnt_ff + 1'b1;
    end

    assign q.qualified = held && (q.delay == '0 ||
        cnt_ff > {1'b0, q.delay});
endmodule

// ---- uaw_top.sv ----
// user alarm and warning unit with apb register access
`timescale 1ns/1ps
module uaw_top
#(
    parameter int SEC_CYCLES = uaw_pkg::SEC_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // drive condition inputs
    input wire logic [7:0] dig_in,
    input wire logic [7:0] ana_cmp,
    input wire logic [7:0] ctl_status,
    input wire logic run_cmd,
    input wire logic drive_running,
    input wire logic closed_loop_active_mode,
    input wire logic fault_reset,
    // fault outputs
    output logic [7:0] user_alarm_trip_flag,
    output logic drive_stop,
    output logic [3:0] warn_active
);
    localparam int NA = uaw_pkg::NUM_ALARMS;
    localparam int NW = uaw_pkg::NUM_WARNS;
    localparam int SEC_W = $clog2(SEC_CYCLES);

    //--------------------------------------------------------------------
    // configuration storage
    //--------------------------------------------------------------------
    uaw_pkg::uaw_mode_t alm_mode_ff [NA];
    logic [uaw_pkg::SRC_W-1:0] alm_src_ff [NA];
    logic [uaw_pkg::DLY_W-1:0] alm_dly_ff [NA];
    uaw_pkg::uaw_mode_t wrn_mode_ff [NW];
    logic [uaw_pkg::SRC_W-1:0] wrn_src_ff [NW];
    logic [31:0] alm_txt_ff [NA*uaw_pkg::ALM_TXT_WORDS];
    logic [31:0] wrn_txt_ff [NW*uaw_pkg::WRN_TXT_WORDS];

    logic [7:0] dig_prev_ff;
    logic [63:0] src_vec;
    logic [SEC_W-1:0] sec_cnt_ff;
    logic tick_ff;
    logic [NA-1:0] trip_ff;
    logic [NA-1:0] nxt_trip;
    logic [NA-1:0] qual;
    logic stop_ff;
    logic [NW-1:0] warn_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_data;
    logic addr_ok;
    logic access;
    logic wr_commit;
    logic trip_clr;

    function automatic logic mode_en(uaw_pkg::uaw_mode_t m, logic run,
        logic running, logic closed);
        logic en;
        en = 1'b0;
        unique case (m)
            uaw_pkg::MODE_ALWAYS: en = 1'b1;
            uaw_pkg::MODE_RUN_CMD: en = run;
            uaw_pkg::MODE_CLOSED_LOOP: en = running & closed;
            uaw_pkg::MODE_OFF: en = 1'b0;
        endcase
        return en;
    endfunction

    //--------------------------------------------------------------------
    // source selection and time base
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dig_prev_ff <= 8'h00;
        else
            dig_prev_ff <= dig_in;
    end

    // edge sources last one cycle, so they only qualify with zero delay
    assign src_vec = {8'h00, ~ctl_status, ctl_status, ~ana_cmp, ana_cmp,
        dig_prev_ff & ~dig_in, dig_in & ~dig_prev_ff, dig_in};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else if (sec_cnt_ff == SEC_W'(SEC_CYCLES - 1))
        begin
            sec_cnt_ff <= '0;
            tick_ff <= 1'b1;
        end
        else
        begin
            sec_cnt_ff <= sec_cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // alarm channels
    //--------------------------------------------------------------------
    assign access = psel & penable;
    assign wr_commit = access & pready_ff & pwrite;
    assign trip_clr = fault_reset | (wr_commit && paddr == uaw_pkg::OFS_CTRL
        && pwdata[uaw_pkg::CTRL_FAULT_RST_BIT]);

    for (genvar i = 0; i < NA; i++)
    begin : g_alm
        uaw_qual_if qif ();
        assign qif.enable = mode_en(alm_mode_ff[i], run_cmd, drive_running,
            closed_loop_active_mode);
        assign qif.cond = src_vec[alm_src_ff[i]];
        assign qif.tick = tick_ff;
        assign qif.delay = alm_dly_ff[i];
        assign qual[i] = qif.qualified;
        uaw_alarm_qual u_qual
        (
            .pclk(pclk),
            .presetn(presetn),
            .q(qif)
        );
        // a trip arriving with a reset survives it
        assign nxt_trip[i] = qual[i] | (trip_ff[i] & ~trip_clr);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_ff <= '0;
            stop_ff <= 1'b0;
        end
        else
        begin
            trip_ff <= nxt_trip;
            stop_ff <= |nxt_trip;
        end
    end

    //--------------------------------------------------------------------
    // warning channels
    //--------------------------------------------------------------------
    for (genvar j = 0; j < NW; j++)
    begin : g_wrn
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                warn_ff[j] <= 1'b0;
            else
                warn_ff[j] <= mode_en(wrn_mode_ff[j], run_cmd, drive_running,
                    closed_loop_active_mode) & src_vec[wrn_src_ff[j]];
        end
    end

    //--------------------------------------------------------------------
    // register writes
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NA; i++)
            begin
                alm_mode_ff[i] <= uaw_pkg::MODE_RST;
                alm_src_ff[i] <= uaw_pkg::SRC_RST;
                alm_dly_ff[i] <= uaw_pkg::DLY_RST;
            end
            for (int j = 0; j < NW; j++)
            begin
                wrn_mode_ff[j] <= uaw_pkg::MODE_RST;
                wrn_src_ff[j] <= uaw_pkg::SRC_RST;
            end
        end
        else if (wr_commit && paddr[11:5] == uaw_pkg::OFS_ALM_CFG[11:5])
        begin
            alm_mode_ff[paddr[4:2]] <= uaw_pkg::uaw_mode_t'(pwdata[1:0]);
            alm_src_ff[paddr[4:2]] <= pwdata[13:8];
            // delays past the maximum are clamped
            alm_dly_ff[paddr[4:2]] <= (pwdata[26:16] > uaw_pkg::DELAY_MAX_S)
                ? uaw_pkg::DELAY_MAX_S : pwdata[26:16];
        end
        else if (wr_commit && paddr[11:4] == uaw_pkg::OFS_WRN_CFG[11:4])
        begin
            wrn_mode_ff[paddr[3:2]] <= uaw_pkg::uaw_mode_t'(pwdata[1:0]);
            wrn_src_ff[paddr[3:2]] <= pwdata[13:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < NA*uaw_pkg::ALM_TXT_WORDS; k++)
                alm_txt_ff[k] <= uaw_pkg::TXT_RST;
            for (int k = 0; k < NW*uaw_pkg::WRN_TXT_WORDS; k++)
                wrn_txt_ff[k] <= uaw_pkg::TXT_RST;
        end
        else if (wr_commit && paddr[11:7] == uaw_pkg::OFS_ALM_TXT[11:7]
            && paddr[3:2] != uaw_pkg::PFX_WORD)
            alm_txt_ff[paddr[6:4]*3 + paddr[3:2]] <= pwdata;
        else if (wr_commit && paddr[11:5] == uaw_pkg::OFS_WRN_TXT[11:5])
            wrn_txt_ff[{paddr[4:3], paddr[2]}] <= pwdata;
    end

    //--------------------------------------------------------------------
    // read decode and apb answer
    //--------------------------------------------------------------------
    always_comb
    begin
        rd_data = 32'h00000000;
        addr_ok = 1'b1;
        if (paddr == uaw_pkg::OFS_CTRL)
            rd_data = 32'h00000000;
        else if (paddr == uaw_pkg::OFS_STATUS)
        begin
            rd_data[NA-1:0] = trip_ff;
            rd_data[uaw_pkg::ST_WARN_LSB +: NW] = warn_ff;
            rd_data[uaw_pkg::ST_STOP_BIT] = stop_ff;
        end
        else if (paddr[11:5] == uaw_pkg::OFS_ALM_CFG[11:5])
        begin
            rd_data[uaw_pkg::CFG_MODE_LSB +: 2] = alm_mode_ff[paddr[4:2]];
            rd_data[uaw_pkg::CFG_SRC_LSB +: uaw_pkg::SRC_W] =
                alm_src_ff[paddr[4:2]];
            rd_data[uaw_pkg::CFG_DLY_LSB +: uaw_pkg::DLY_W] =
                alm_dly_ff[paddr[4:2]];
        end
        else if (paddr[11:4] == uaw_pkg::OFS_WRN_CFG[11:4])
        begin
            rd_data[uaw_pkg::CFG_MODE_LSB +: 2] = wrn_mode_ff[paddr[3:2]];
            rd_data[uaw_pkg::CFG_SRC_LSB +: uaw_pkg::SRC_W] =
                wrn_src_ff[paddr[3:2]];
        end
        else if (paddr[11:7] == uaw_pkg::OFS_ALM_TXT[11:7])
        begin
            if (paddr[3:2] == uaw_pkg::PFX_WORD)
                rd_data = {uaw_pkg::PFX_LETTERS,
                    uaw_pkg::PFX_DIGIT_ONE + {5'h00, paddr[6:4]},
                    uaw_pkg::PFX_COLON};
            else
                rd_data = alm_txt_ff[paddr[6:4]*3 + paddr[3:2]];
        end
        else if (paddr[11:5] == uaw_pkg::OFS_WRN_TXT[11:5])
            rd_data = wrn_txt_ff[{paddr[4:3], paddr[2]}];
        else
            addr_ok = 1'b0;
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end
        else if (access && !pready_ff)
        begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~addr_ok;
            prdata_ff <= pwrite ? 32'h00000000 : rd_data;
        end
        else
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign user_alarm_trip_flag = trip_ff;
    assign drive_stop = stop_ff;
    assign warn_active = warn_ff;
endmodule

// ---- uaw_top_chk.sv ----
// port assertions of the user alarm and warning unit
`timescale 1ns/1ps
module uaw_top_chk
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // faults
    input wire logic fault_reset,
    input wire logic [7:0] user_alarm_trip_flag,
    input wire logic drive_stop
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd = pready && !pwrite;
    // both clear paths: the input and a write of one to the control word
    wire logic clr = fault_reset || (pready && pwrite && pwdata[0]
        && paddr == uaw_pkg::OFS_CTRL);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    property p_apb_lat;
        s_setup |=> s_answer;
    endproperty
    a_apb_lat: assert property (p_apb_lat) else $error("late answer");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_stop;
        drive_stop == |user_alarm_trip_flag;
    endproperty
    a_stop: assert property (p_stop) else $error("stop mismatch");
    property p_hold;
        |($past(user_alarm_trip_flag) & ~user_alarm_trip_flag) |-> $past(clr);
    endproperty
    a_hold: assert property (p_hold) else $error("trip lost");
    property p_stop_hold;
        drive_stop && !clr |=> drive_stop;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop lost");
    property p_ctrl_rd;
        rd && paddr == uaw_pkg::OFS_CTRL |-> prdata == 32'h00000000;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl not 0");
    property p_prefix;
        rd && paddr[11:7] == 5'h02 && paddr[3:2] == 2'h3 |-> prdata ==
            {16'h5541, 8'h31 + {5'h00, paddr[6:4]}, 8'h3A};
    endproperty
    a_prefix: assert property (p_prefix) else $error("bad prefix");
endmodule
bind uaw_top uaw_top_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_reset(fault_reset), .user_alarm_trip_flag(user_alarm_trip_flag),
    .drive_stop(drive_stop));

// ---- uaw_drive_model.sv ----
// drive run control model facing the unit's fault outputs
`timescale 1ns/1ps
module uaw_drive_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic start,
    input wire logic want_cl,
    // unit side
    input wire logic drive_stop,
    output logic run_cmd,
    output logic drive_running,
    output logic closed_loop_active_mode
);
    logic running_ff;
    assign run_cmd = start;
    // a trip halts the drive while the run command stays
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            running_ff <= 1'h0;
        else
            running_ff <= start && !drive_stop;
    end
    assign drive_running = running_ff;
    assign closed_loop_active_mode = running_ff && want_cl;
endmodule

// ---- tb_uaw_top.sv ----
// self-checking bench of the user alarm and warning unit
`timescale 1ns/1ps
module tb_uaw_top;
    localparam int SEC = 10;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, start = 1'h0, want_cl = 1'h0, fault_reset = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, run_cmd, running, clm, drive_stop, ev;
    logic [7:0] dig_in = 8'h00, ana_cmp = 8'h00, ctl_status = 8'h00, trip;
    logic [3:0] warn;
    logic [32:0] exp_q[$], e;
    int fails = 0, checks = 0, seed = 32'hFBF1, n;
    always #5 pclk = ~pclk;
    uaw_top #(.SEC_CYCLES(SEC)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dig_in(dig_in), .ana_cmp(ana_cmp),
        .ctl_status(ctl_status), .run_cmd(run_cmd), .drive_running(running),
        .closed_loop_active_mode(clm), .fault_reset(fault_reset),
        .user_alarm_trip_flag(trip), .drive_stop(drive_stop),
        .warn_active(warn));
    uaw_drive_model u_drv (.pclk(pclk), .presetn(presetn), .start(start),
        .want_cl(want_cl), .drive_stop(drive_stop), .run_cmd(run_cmd),
        .drive_running(running), .closed_loop_active_mode(clm));
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // one idle cycle between transfers keeps every strobe single-driven
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++k < 20);
        psel <= 1'h0;
        penable <= 1'h0;
        if (k >= 20)
        begin
            fails++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic err);
        exp_q.push_back({err, d});
        apb(1'h0, a, 32'h0);
    endtask
    task automatic clear;
        @(posedge pclk);
        fault_reset <= 1'h1;
        cyc(1);
        fault_reset <= 1'h0;
        cyc(1);
    endtask
    function automatic logic [31:0] cfg(input logic [1:0] md,
        input logic [5:0] s, input logic [10:0] d);
        return {5'h00, d, 2'h0, s, 6'h00, md};
    endfunction
    always @(posedge pclk)
    begin
        if (pready === 1'h1 && psel && !pwrite)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1FFFFFFFF;
            chk({31'h0, pslverr}, {31'h0, e[32]});
            if (!e[32])
                chk(prdata, e[31:0]);
        end
    end
    initial
    begin
        cyc(16);
        presetn <= 1'h1;
        rd(uaw_pkg::OFS_ALM_CFG, cfg(2'h3, 6'h00, 11'h000), 1'h0);
        rd(uaw_pkg::OFS_WRN_TXT, uaw_pkg::TXT_RST, 1'h0);
        rd(12'hFFC, 32'h0, 1'h1);
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            apb(1'h1, uaw_pkg::OFS_ALM_TXT + 12'(16 * i + 4 * (i % 3)), r);
            rd(uaw_pkg::OFS_ALM_TXT + 12'(16 * i + 4 * (i % 3)), r,
                1'h0);
            apb(1'h1, uaw_pkg::OFS_ALM_TXT + 12'(16 * i + 12), r);
            rd(uaw_pkg::OFS_ALM_TXT + 12'(16 * i + 12),
                {16'h5541, 8'(8'h31 + i), 8'h3A}, 1'h0);
            // every text word of every warning gets written once
            n = 8 * (i % 4) + 4 * (i / 4);
            apb(1'h1, uaw_pkg::OFS_WRN_TXT + 12'(n), ~r);
            rd(uaw_pkg::OFS_WRN_TXT + 12'(n), ~r, 1'h0);
        end
        apb(1'h1, uaw_pkg::OFS_ALM_CFG, cfg(2'h3, 6'h00, 11'h7D0));
        rd(uaw_pkg::OFS_ALM_CFG, cfg(2'h3, 6'h00, 11'h4B0), 1'h0);
        $display("registers done");
        for (int k = 0; k < 8; k++)
        begin
            r = (k == 2 || k == 4 || k == 6) ? 32'hFF : 32'h0;
            dig_in <= (k < 3 || k == 7) ? r[7:0] : 8'($random(seed));
            ana_cmp <= (k == 3 || k == 4) ? r[7:0] : 8'($random(seed));
            ctl_status <= (k == 5 || k == 6) ? r[7:0] : 8'($random(seed));
            apb(1'h1, uaw_pkg::OFS_ALM_CFG, cfg(2'h0, 6'(8 * k), 11'h000));
            clear();
            dig_in <= (k < 3 || k == 7) ? ~r[7:0] : dig_in;
            ana_cmp <= (k == 3 || k == 4) ? ~r[7:0] : ana_cmp;
            ctl_status <= (k == 5 || k == 6) ? ~r[7:0] : ctl_status;
            cyc(3);
            chk({24'h0, trip}, k == 7 ? 32'h0 : 32'h1);
        end
        $display("sources done");
        for (int k = 0; k < 18; k++)
        begin
            apb(1'h1, uaw_pkg::OFS_ALM_CFG, cfg(2'h3, 6'h00, 11'h000));
            apb(1'h1, uaw_pkg::OFS_WRN_CFG, cfg(2'h3, 6'h00, 11'h000));
            clear();
            start <= (k / 3) % 3 > 0;
            want_cl <= (k / 3) % 3 == 2;
            dig_in <= 8'h01;
            cyc(3);
            apb(1'h1, k >= 9 ? uaw_pkg::OFS_WRN_CFG : uaw_pkg::OFS_ALM_CFG,
                cfg(2'(k % 3), 6'h00, 11'h000));
            cyc(3);
            ev = k % 3 == 0 || (k % 3 > 0 && (k / 3) % 3 >= k % 3);
            r = k >= 9 ? 32'h100 : 32'h1001;
            rd(uaw_pkg::OFS_STATUS, ev ? r : 32'h0, 1'h0);
        end
        // each warning watches its own terminal so channels cannot alias
        for (int j = 0; j < 4; j++)
        begin
            apb(1'h1, uaw_pkg::OFS_WRN_CFG + 12'(4 * j),
                cfg(2'h0, 6'(j + 1), 11'h000));
            rd(uaw_pkg::OFS_WRN_CFG + 12'(4 * j),
                cfg(2'h0, 6'(j + 1), 11'h000), 1'h0);
        end
        r = $random(seed);
        dig_in <= r[7:0];
        cyc(3);
        chk({28'h0, warn}, {28'h0, r[4:1]});
        rd(uaw_pkg::OFS_STATUS, {20'h0, r[4:1], 8'h00}, 1'h0);
        dig_in <= 8'h00;
        cyc(3);
        chk({27'h0, drive_stop, warn}, 32'h0);
        $display("modes done");
        for (int i = 0; i < 8; i++)
            apb(1'h1, uaw_pkg::OFS_ALM_CFG + 12'(4 * i),
                cfg(2'h0, 6'(i), 11'h000));
        clear();
        r = $random(seed);
        dig_in <= r[7:0];
        cyc(3);
        chk({24'h0, trip}, {24'h0, r[7:0]});
        dig_in <= 8'h00;
        apb(1'h1, uaw_pkg::OFS_ALM_CFG, cfg(2'h0, 6'h00, 11'h002));
        clear();
        dig_in <= 8'h01;
        cyc(15);
        dig_in <= 8'h00;
        cyc(2);
        dig_in <= 8'h01;
        n = 0;
        do cyc(1); while (trip[0] !== 1'h1 && ++n < 60);
        chk({31'h0, n >= 20 && n <= 33}, 32'h1);
        dig_in <= 8'h00;
        cyc(5);
        chk({24'h0, trip}, 32'h1);
        apb(1'h1, uaw_pkg::OFS_CTRL, 32'h1);
        rd(uaw_pkg::OFS_STATUS, 32'h0, 1'h0);
        rd(uaw_pkg::OFS_CTRL, 32'h0, 1'h0);
        apb(1'h1, uaw_pkg::OFS_ALM_CFG, cfg(2'h0, 6'h00, 11'h000));
        dig_in <= 8'h01;
        fault_reset <= 1'h1;
        cyc(3);
        chk({24'h0, trip}, 32'h1);
        dig_in <= 8'h00;
        fault_reset <= 1'h0;
        clear();
        chk({24'h0, trip}, 32'h0);
        $display("delay and clear done");
        cyc(2);
        complete_run();
    end
endmodule
